/* rtl/jla_pkg.sv */
/*
  Shared constants for the latency alignment pair: register map of the
  receiving device, field positions, reset values, host command map.
  Assumes both ends run on one clock, ref_clk.
*/
package jla_pkg;
  localparam int AW = 12;
  localparam int RW = 8;
  localparam int DW = 16;
  localparam int FIFO_D = 16;
  // Device register offsets
  localparam logic [AW-1:0] A_SYNC = 12'h03A;
  localparam logic [AW-1:0] A_LINK = 12'h300;
  localparam logic [AW-1:0] A_SUBC = 12'h301;
  localparam logic [AW-1:0] A_LAT0 = 12'h302;
  localparam logic [AW-1:0] A_LAT1 = 12'h303;
  localparam logic [AW-1:0] A_DEL = 12'h304;
  localparam logic [AW-1:0] A_WIN = 12'h305;
  localparam logic [AW-1:0] A_PCMF = 12'h306;
  localparam logic [AW-1:0] A_OCT = 12'h307;
  localparam logic [AW-1:0] A_STAT = 12'h30C;
  // Sync control values and fields
  localparam logic [RW-1:0] SYNC_ONESHOT = 8'h01;
  localparam logic [RW-1:0] SYNC_ENABLE = 8'h81;
  localparam logic [RW-1:0] SYNC_ARMED = 8'hC1;
  localparam int SYNC_EN_BIT = 7;
  localparam int SYNC_ARM_BIT = 6;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  // Link enable fields
  localparam int CHK_BIT = 6;
  localparam int DUAL_BIT = 3;
  localparam logic [1:0] EN_BOTH = 2'h3;
  localparam logic [1:0] EN_ZERO = 2'h1;
  // Limits and reset values
  localparam logic [RW-1:0] WIN_MAX = 8'h0A;
  localparam logic [RW-1:0] PCMF_RST = 8'h10;
  localparam logic [RW-1:0] OCT_RST = 8'h02;
  localparam logic [RW-1:0] ZERO8 = 8'h00;
  localparam logic [RW-1:0] ONE8 = 8'h01;
  localparam logic [4:0] RUNS = 5'h14;
  localparam logic [7:0] WAIT_CYC = 8'h40;
  // Host command map
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_SUBC = 4'h1;
  localparam logic [3:0] H_LINK = 4'h2;
  localparam logic [3:0] H_PCMF = 4'h3;
  localparam logic [3:0] H_OCT = 4'h4;
  localparam logic [3:0] H_FIXQ = 4'h5;
  localparam logic [3:0] H_VARQ = 4'h6;
  localparam logic [3:0] H_MIN = 4'h7;
  localparam logic [3:0] H_MAX = 4'h8;
  localparam logic [3:0] H_DEL = 4'h9;
  localparam logic [3:0] H_WIN = 4'hA;
  localparam logic [3:0] H_STAT = 4'hB;
  localparam int Q_BITS = 2;
  localparam logic [RW-1:0] Q_RND = 8'h03;

  // Frame clocks per processing-clock cycle, four over octets per frame
  function automatic logic [RW-1:0] frames_per_proc_cycle(input logic [RW-1:0] f);
    case (f)
      8'h01: frames_per_proc_cycle = 8'h04;
      8'h02: frames_per_proc_cycle = 8'h02;
      default: frames_per_proc_cycle = 8'h01;
    endcase
  endfunction
endpackage

/* rtl/jla_if.sv */
/*
  Link between the transmitter end and the receiving device: register
  port, alignment edge, lane multiframe markers and the data stream.
  Assumes both ends share ref_clk; no clocking block.
*/
`timescale 1ns/1ps
interface jla_if;
  import jla_pkg::*;
  logic [AW-1:0] reg_addr;
  logic [RW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [RW-1:0] reg_rdata;
  logic sysref;
  logic [1:0] mf_edge;
  logic tx_valid;
  logic [DW-1:0] tx_data;
  logic tx_ready;
  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, sysref, mf_edge, tx_valid, tx_data,
    output reg_rdata, tx_ready
  );
  modport tx (
    output reg_addr, reg_wdata, reg_wr, reg_rd, sysref, mf_edge, tx_valid, tx_data,
    input reg_rdata, tx_ready
  );
endinterface

/* rtl/jla_rx_end.sv */
/*
  Receiving device end: sync machine, link enable and configuration,
  per-link latency measurement, release delay and variable-delay window.
  Assumes the transmitter end on the same clock drives the register port.
*/
// Notes on behaviour
// R1 - Measure per-link latency, readable by software
// R2 - Latency wraps within one multiframe
// R3 - Link zero at 0x302, link one next
// R4 - Window saturates at ten cycles
// R5 - Value 0x01 selects one-shot, not enabled
// R6 - Top bit plus one-shot enables machine
// R7 - Both upper bits plus one-shot arms machine
// R8 - Send SYSREF edge after arm, before links
// R9 - Program subclass before any sync writes
// R10 - Link register: checksum 6, dual 3, enable [1:0]
// R11 - Release delay from minimum less one, modulo
// R12 - Same delay and window everywhere
// R13 - Window is guarded max minus guarded min
// R14 - Remap readings near zero on rollover
// R15 - Pool twenty runs of readings
// R16 - Known delays: floor fixed, ceiling total
// R17 - Count delays in processing-clock cycles
// R18 - Frame factor is four over octets
// R19 - One-shot disarms until armed again
`timescale 1ns/1ps
module jla_rx_end
  import jla_pkg::*;
(
  jla_if.dev lnk,
  input wire logic ref_clk,
  input wire logic rst,
  output logic [DW-1:0] rx_data,
  output logic rx_valid,
  output logic aligned,
  output logic release_pulse
);
  logic [RW-1:0] sync_r, sync_nxt;
  logic [RW-1:0] link_r, link_nxt;
  logic [RW-1:0] subc_r, subc_nxt;
  logic [RW-1:0] del_r, del_nxt;
  logic [RW-1:0] win_r, win_nxt;
  logic [RW-1:0] pcmf_r, pcmf_nxt;
  logic [RW-1:0] oct_r, oct_nxt;
  logic [RW-1:0] lmfc_r, lmfc_nxt;
  logic [RW-1:0] lat_r [2];
  logic [RW-1:0] lat_nxt [2];
  logic aligned_r, aligned_nxt;
  logic sref_q_r;
  logic [RW-1:0] rdata_nxt;
  logic ready_nxt;
  logic [DW-1:0] rxd_nxt;
  logic rxv_nxt;
  logic rel_nxt;
  logic sref_rise;
  logic align_evt;
  logic [RW-1:0] rel_pc;
  logic [RW-1:0] mf_last;
  logic wr_hit;

  // Alignment event: subclass 1 waits for a SYSREF rising edge, subclass 0
  // aligns on the internal clock as soon as the machine is armed
  always_comb begin
    sref_rise = lnk.sysref & ~sref_q_r;
    align_evt = sync_r[SYNC_EN_BIT] & sync_r[SYNC_ARM_BIT]   // see R6, R7
      & (sync_r[1:0] == MODE_ONESHOT)                         // see R5
      & (subc_r[0] ? sref_rise : 1'b1);
    mf_last = (pcmf_r == ZERO8) ? ZERO8 : pcmf_r - ONE8;
    // Release delay is held in frame clocks in subclass 1
    rel_pc = subc_r[0] ? del_r / frames_per_proc_cycle(oct_r) : del_r; // see R18
    wr_hit = lnk.reg_wr;
  end

  // Register writes; a write to the arm bit beats the hardware clear
  always_comb begin
    sync_nxt = sync_r;
    link_nxt = link_r;
    subc_nxt = subc_r;
    del_nxt = del_r;
    win_nxt = win_r;
    pcmf_nxt = pcmf_r;
    oct_nxt = oct_r;
    if (align_evt) begin
      sync_nxt[SYNC_ARM_BIT] = 1'b0; // see R19
    end
    if (wr_hit) begin
      case (lnk.reg_addr)
        A_SYNC: sync_nxt = lnk.reg_wdata; // see R5, R6, R7
        A_LINK: link_nxt = lnk.reg_wdata; // see R10
        A_SUBC: subc_nxt = lnk.reg_wdata;
        A_DEL: del_nxt = lnk.reg_wdata;
        A_WIN: begin
          // Wider windows cannot be absorbed, so they clip at the limit
          win_nxt = (lnk.reg_wdata > WIN_MAX) ? WIN_MAX : lnk.reg_wdata; // see R4
        end
        A_PCMF: pcmf_nxt = lnk.reg_wdata;
        A_OCT: oct_nxt = lnk.reg_wdata;
        default: ;
      endcase
    end
  end

  // Receive multiframe counter and latency capture
  always_comb begin
    aligned_nxt = aligned_r | align_evt;
    if (align_evt) begin
      lmfc_nxt = ZERO8;
    end else if (lmfc_r >= mf_last) begin
      lmfc_nxt = ZERO8; // see R2
    end else begin
      lmfc_nxt = lmfc_r + ONE8; // see R17
    end
    for (int l = 0; l < 2; l++) begin
      lat_nxt[l] = lat_r[l];
      // Counter phase at the last lane boundary is the link latency
      if (lnk.mf_edge[l] && link_r[l]) begin
        lat_nxt[l] = lmfc_r; // see R1
      end
    end
    rel_nxt = aligned_r & (lmfc_r == rel_pc);
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = ZERO8;
    if (lnk.reg_rd) begin
      case (lnk.reg_addr)
        A_SYNC: rdata_nxt = sync_r;
        A_LINK: rdata_nxt = link_r;
        A_SUBC: rdata_nxt = subc_r;
        A_LAT0: rdata_nxt = lat_r[0]; // see R3
        A_LAT1: rdata_nxt = lat_r[1]; // see R3
        A_DEL: rdata_nxt = del_r;
        A_WIN: rdata_nxt = win_r;
        A_PCMF: rdata_nxt = pcmf_r;
        A_OCT: rdata_nxt = oct_r;
        A_STAT: rdata_nxt = {5'h00, link_r[0], aligned_r, sync_r[SYNC_ARM_BIT]};
        default: rdata_nxt = ZERO8;
      endcase
    end
  end

  // Data is taken only once link zero is enabled and aligned
  always_comb begin
    ready_nxt = aligned_r & link_r[0];
    rxv_nxt = lnk.tx_valid & lnk.tx_ready;
    rxd_nxt = rxv_nxt ? lnk.tx_data : rx_data;
  end

  // State registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_r <= ZERO8;
      link_r <= ZERO8;
      subc_r <= ZERO8;
      del_r <= ZERO8;
      win_r <= ZERO8;
      pcmf_r <= PCMF_RST;
      oct_r <= OCT_RST;
      lmfc_r <= ZERO8;
      lat_r[0] <= ZERO8;
      lat_r[1] <= ZERO8;
      aligned_r <= 1'b0;
      sref_q_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      link_r <= link_nxt;
      subc_r <= subc_nxt;
      del_r <= del_nxt;
      win_r <= win_nxt;
      pcmf_r <= pcmf_nxt;
      oct_r <= oct_nxt;
      lmfc_r <= lmfc_nxt;
      lat_r[0] <= lat_nxt[0];
      lat_r[1] <= lat_nxt[1];
      aligned_r <= aligned_nxt;
      sref_q_r <= lnk.sysref;
    end
  end

  // Output registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.reg_rdata <= ZERO8;
      lnk.tx_ready <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      aligned <= 1'b0;
      release_pulse <= 1'b0;
    end else begin
      lnk.reg_rdata <= rdata_nxt;
      lnk.tx_ready <= ready_nxt;
      rx_data <= rxd_nxt;
      rx_valid <= rxv_nxt;
      aligned <= aligned_nxt;
      release_pulse <= rel_nxt;
    end
  end
endmodule

/* rtl/jla_tx_end.sv */
/*
  Transmitter end: data FIFO, lane multiframe markers, one-shot sync
  sequence, latency collection over many runs and delay computation.
  Assumes the device end on the same clock behind jla_if.
*/
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module jla_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;
  logic rdy_r, rdy_nxt;

  // Ready is registered from the next count, so it is exact and leaves from a flop
  always_comb begin
    in_ready = rdy_r;
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    rdy_nxt = (cnt_nxt != D[PW:0]);
    out_valid = (cnt_r != '0);
    out_data = mem[rp_r];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // Storage carries no reset
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

module jla_tx_end
  import jla_pkg::*;
(
  jla_if.tx lnk,
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] cmd_addr,
  input wire logic [RW-1:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [RW-1:0] cmd_rdata,
  input wire logic in_valid,
  input wire logic [DW-1:0] in_data,
  output logic in_ready
);
  typedef enum logic [12:0] {
    S_IDLE = 13'h0001, S_SUB = 13'h0002, S_MODE = 13'h0004, S_EN = 13'h0008,
    S_ARM = 13'h0010, S_SREF = 13'h0020, S_LINK = 13'h0040, S_WAIT = 13'h0080,
    S_RD0 = 13'h0100, S_RD1 = 13'h0200, S_CAP = 13'h0400, S_CALC = 13'h0800,
    S_PROG = 13'h1000
  } jla_state_t;
  jla_state_t st_r, st_nxt;
  logic [RW-1:0] subc_r, link_r, pcmf_r, oct_r, fixq_r, varq_r, ctrl_r;
  logic [RW-1:0] lo_min_r, lo_max_r, hi_min_r, hi_max_r, mn_r, mx_r, del_r, win_r;
  logic lo_any_r, hi_any_r, busy_r, done_r, second_r;
  logic [4:0] run_r;
  logic [7:0] wait_r, mf_r;
  logic [RW-1:0] a_mn, a_mx, a_del, a_win, fac, half, rd_v;
  logic [RW+1:0] tot;
  logic f_valid, f_ready, f_push;
  logic [DW-1:0] f_data;

  jla_fifo #(.W(DW), .D(FIFO_D)) u_fifo (
    .ref_clk(ref_clk), .rst(rst), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(f_valid), .out_data(f_data),
    .out_ready(f_ready)
  );

  // Stream drains when the device signals ready; back-pressure fills it
  always_comb begin
    // Pop exactly when the output register loads, or a word is sent twice
    f_push = ~lnk.tx_valid | lnk.tx_ready;
    f_ready = f_push;
    rd_v = lnk.reg_rdata;
    fac = frames_per_proc_cycle(oct_r); // see R18
    half = pcmf_r >> 1;
    tot = {2'b00, fixq_r} + {2'b00, varq_r} + {2'b00, Q_RND};
    // Minimum and maximum from the known delays or the pooled readings, low group lifted on rollover
    if (ctrl_r[1]) begin
      a_mn = fixq_r >> Q_BITS;              // see R16
      a_mx = tot[RW+1:Q_BITS];              // see R16
    end else if (lo_any_r && hi_any_r) begin
      a_mn = hi_min_r;                      // see R14
      a_mx = lo_max_r + pcmf_r;             // see R14
    end else if (hi_any_r) begin
      a_mn = hi_min_r;
      a_mx = hi_max_r;
    end else begin
      a_mn = lo_min_r;
      a_mx = lo_max_r;
    end
    a_win = (a_mx + ONE8) - (a_mn - ONE8);  // see R13
    if (subc_r[0]) begin
      a_del = ((a_mn - ONE8) * fac) % (pcmf_r * fac); // see R11
    end else begin
      a_del = (a_mn - ONE8) % pcmf_r;       // see R11
    end
  end

  // Sequencer: subclass first, then mode, enable, arm, edge, links
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (cmd_wr && cmd_addr == H_CTRL && cmd_wdata[0]) begin
        st_nxt = cmd_wdata[1] ? S_CALC : S_SUB;
      end
      S_SUB: st_nxt = S_MODE;               // see R9
      S_MODE: st_nxt = S_EN;
      S_EN: st_nxt = S_ARM;
      S_ARM: st_nxt = S_SREF;
      S_SREF: st_nxt = S_LINK;              // see R8
      S_LINK: st_nxt = S_WAIT;
      S_WAIT: if (wait_r == WAIT_CYC) begin
        st_nxt = S_RD0;
      end
      S_RD0: st_nxt = S_RD1;
      S_RD1: st_nxt = S_CAP;
      S_CAP: st_nxt = (run_r == RUNS - 5'h01) ? S_CALC : S_SUB; // see R15
      S_CALC: st_nxt = S_PROG;
      S_PROG: if (second_r) begin
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Command registers, link drive, accumulation and results
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE;
      {subc_r, link_r, fixq_r, varq_r, ctrl_r} <= '0;
      pcmf_r <= PCMF_RST;
      oct_r <= OCT_RST;
      {lo_max_r, hi_max_r, mn_r, mx_r, del_r, win_r} <= '0;
      lo_min_r <= 8'hFF;
      hi_min_r <= 8'hFF;
      {lo_any_r, hi_any_r, busy_r, done_r, second_r} <= '0;
      run_r <= '0;
      wait_r <= '0;
      mf_r <= '0;
      lnk.reg_addr <= '0;
      lnk.reg_wdata <= '0;
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      lnk.sysref <= 1'b0;
      lnk.mf_edge <= '0;
      lnk.tx_valid <= 1'b0;
      lnk.tx_data <= '0;
      cmd_rdata <= '0;
    end else begin
      st_r <= st_nxt;
      if (f_push) begin
        lnk.tx_valid <= f_valid;
        lnk.tx_data <= f_data;
      end
      // Transmit multiframe markers on both links
      mf_r <= (mf_r + 8'h01 >= pcmf_r) ? 8'h00 : mf_r + 8'h01;
      lnk.mf_edge <= {2{mf_r == 8'h00}};
      if (cmd_wr) begin
        case (cmd_addr)
          H_CTRL: ctrl_r <= cmd_wdata;
          H_SUBC: subc_r <= cmd_wdata;
          H_LINK: link_r <= cmd_wdata;
          H_PCMF: pcmf_r <= cmd_wdata;
          H_OCT: oct_r <= cmd_wdata;
          H_FIXQ: fixq_r <= cmd_wdata;
          H_VARQ: varq_r <= cmd_wdata;
          default: ;
        endcase
      end
      case (cmd_addr)
        H_CTRL: cmd_rdata <= ctrl_r;
        H_SUBC: cmd_rdata <= subc_r;
        H_LINK: cmd_rdata <= link_r;
        H_PCMF: cmd_rdata <= pcmf_r;
        H_OCT: cmd_rdata <= oct_r;
        H_FIXQ: cmd_rdata <= fixq_r;
        H_VARQ: cmd_rdata <= varq_r;
        H_MIN: cmd_rdata <= mn_r;
        H_MAX: cmd_rdata <= mx_r;
        H_DEL: cmd_rdata <= del_r;
        H_WIN: cmd_rdata <= win_r;
        H_STAT: cmd_rdata <= {5'h00, win_r > WIN_MAX, done_r, busy_r}; // see R4
        default: cmd_rdata <= ZERO8;
      endcase
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      lnk.sysref <= 1'b0;
      wait_r <= (st_r == S_WAIT) ? wait_r + 8'h01 : 8'h00;
      if (st_r == S_IDLE && st_nxt != S_IDLE) begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        run_r <= '0;
        {lo_any_r, hi_any_r, lo_max_r, hi_max_r} <= '0;
        lo_min_r <= 8'hFF;
        hi_min_r <= 8'hFF;
      end
      case (st_r)
        S_SUB: {lnk.reg_wr, lnk.reg_addr, lnk.reg_wdata} <= {1'b1, A_SUBC, subc_r};
        S_MODE: {lnk.reg_wr, lnk.reg_addr, lnk.reg_wdata} <= {1'b1, A_SYNC, SYNC_ONESHOT};
        S_EN: {lnk.reg_wr, lnk.reg_addr, lnk.reg_wdata} <= {1'b1, A_SYNC, SYNC_ENABLE};
        S_ARM: {lnk.reg_wr, lnk.reg_addr, lnk.reg_wdata} <= {1'b1, A_SYNC, SYNC_ARMED};
        S_SREF: lnk.sysref <= subc_r[0];    // see R8
        S_LINK: {lnk.reg_wr, lnk.reg_addr, lnk.reg_wdata} <= {1'b1, A_LINK, link_r};
        S_WAIT: if (st_nxt == S_RD0) begin
          {lnk.reg_rd, lnk.reg_addr} <= {1'b1, A_LAT0};
        end
        S_RD0: {lnk.reg_rd, lnk.reg_addr} <= {1'b1, A_LAT1};
        S_RD1, S_CAP: begin
          // Link one counts only when both links are enabled
          if (st_r == S_RD1 || link_r[1:0] == EN_BOTH) begin
            if (rd_v < half) begin
              lo_any_r <= 1'b1;
              if (rd_v < lo_min_r) lo_min_r <= rd_v;
              if (rd_v > lo_max_r) lo_max_r <= rd_v;
            end else begin
              hi_any_r <= 1'b1;
              if (rd_v < hi_min_r) hi_min_r <= rd_v;
              if (rd_v > hi_max_r) hi_max_r <= rd_v;
            end
          end
          if (st_r == S_CAP) run_r <= run_r + 5'h01;
        end
        S_CALC: begin
          {mn_r, mx_r, del_r, win_r} <= {a_mn, a_mx, a_del, a_win};
          second_r <= 1'b0;
        end
        S_PROG: begin
          // One pair of values is shared by every link
          lnk.reg_wr <= 1'b1;                // see R12
          lnk.reg_addr <= second_r ? A_WIN : A_DEL;
          lnk.reg_wdata <= second_r ? win_r : del_r;
          second_r <= 1'b1;
          if (second_r) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end
endmodule

/* dv/jla_props.sv */
/*
  Checker on the link between the two ends: register traffic, alignment
  edge and ready. Assumes one clock and signals wired in by name.
*/
`timescale 1ns/1ps
module jla_props
  import jla_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [RW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [RW-1:0] reg_rdata,
  input wire logic sysref,
  input wire logic tx_ready
);
  logic subc_r;
  logic seen_r;
  logic link_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Subclass, edge since arming, link zero enable; arm write clears so stale edges do not count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      subc_r <= 1'b0;
      seen_r <= 1'b0;
      link_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == A_SUBC) subc_r <= reg_wdata[0];
      if (reg_wr && reg_addr == A_SYNC && reg_wdata == SYNC_ARMED) seen_r <= 1'b0;
      else if (sysref) seen_r <= 1'b1;
      if (reg_wr && reg_addr == A_LINK) link_r <= reg_wdata[0];
    end
  end

  a_rdata_after_read: assert property ((reg_rdata != ZERO8) |-> $past(reg_rd))
    else $error("read data outside its cycle");
  a_lat_in_frame: assert property ((reg_rd && (reg_addr == A_LAT0 || reg_addr == A_LAT1))
    |=> (reg_rdata < PCMF_RST))
    else $error("latency reading beyond one multiframe");
  a_lat_pair: assert property ((reg_rd && reg_addr == A_LAT0)
    |=> (reg_rd && reg_addr == A_LAT1))
    else $error("link one reading does not follow link zero");
  a_subc_first: assert property ((reg_wr && reg_addr == A_SYNC && reg_wdata == SYNC_ONESHOT)
    |-> $past(reg_wr && reg_addr == A_SUBC))
    else $error("subclass not written before sync mode");
  a_enable_next: assert property ((reg_wr && reg_addr == A_SYNC && reg_wdata == SYNC_ONESHOT)
    |=> (reg_wr && reg_addr == A_SYNC && reg_wdata == SYNC_ENABLE))
    else $error("enable does not follow one-shot mode");
  a_arm_next: assert property ((reg_wr && reg_addr == A_SYNC && reg_wdata == SYNC_ENABLE)
    |=> (reg_wr && reg_addr == A_SYNC && reg_wdata == SYNC_ARMED))
    else $error("arm does not follow enable");
  a_edge_before_link: assert property ((reg_wr && reg_addr == A_LINK && subc_r)
    |-> seen_r)
    else $error("links enabled with no alignment edge");
  a_edge_pulse: assert property (sysref |=> !sysref)
    else $error("alignment edge longer than a cycle");
  a_ready_link: assert property (tx_ready |-> $past(link_r))
    else $error("ready while link zero disabled");
  a_link_then_read: assert property ((reg_wr && reg_addr == A_LINK)
    |-> ##[1:80] (reg_rd && reg_addr == A_LAT0))
    else $error("no latency read after link enable");
endmodule

/* dv/tb_top.sv */
/*
  Bench for the alignment pair: drives the host port and data stream of
  the transmitter end, watches the device outputs and the link.
  Assumes the package constants and the hand-over reset values.
*/
`timescale 1ns/1ps
module tb_top;
  import jla_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] cmd_addr = 4'h0;
  logic [RW-1:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [RW-1:0] cmd_rdata;
  logic in_valid = 1'b0;
  logic [DW-1:0] in_data = 16'h0000;
  logic in_ready, rx_valid, aligned, release_pulse, lat_pend = 1'b0;
  logic [DW-1:0] rx_data;
  logic [RW-1:0] del_w = 8'h00, win_w = 8'h00;
  logic [RW-1:0] pool[$];
  logic [DW-1:0] got_q[$];
  int n_mismatch = 0, samples_checked = 0, n_push = 0, n_sysref = 0;

  jla_if lnk();
  jla_rx_end u_jla_rx_end (.lnk(lnk), .ref_clk(ref_clk), .rst(rst), .rx_data(rx_data),
    .rx_valid(rx_valid), .aligned(aligned), .release_pulse(release_pulse));
  jla_tx_end u_jla_tx_end (.lnk(lnk), .ref_clk(ref_clk), .rst(rst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready));
  jla_props u_jla_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
    .reg_rdata(lnk.reg_rdata), .sysref(lnk.sysref), .tx_ready(lnk.tx_ready));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Link monitor: pooled latency readings, edges, written results, received words
  always @(posedge ref_clk) begin
    if (lat_pend) pool.push_back(lnk.reg_rdata);
    lat_pend <= lnk.reg_rd && (lnk.reg_addr == A_LAT0 || lnk.reg_addr == A_LAT1);
    if (lnk.sysref) n_sysref++;
    if (lnk.reg_wr && lnk.reg_addr == A_LINK) chk("linkcfg", lnk.reg_wdata, 8'h4B);
    if (lnk.reg_wr && lnk.reg_addr == A_DEL) del_w <= lnk.reg_wdata;
    if (lnk.reg_wr && lnk.reg_addr == A_WIN) win_w <= lnk.reg_wdata;
    if (rx_valid) got_q.push_back(rx_data);
  end

  // Each task waits an edge first, so a strobe is never set and cleared in one step
  task automatic wr(input logic [3:0] a, input logic [RW-1:0] d);
    @(posedge ref_clk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [RW-1:0] d);
    @(posedge ref_clk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    // Read data follows the address one cycle later and stays while it is held; the strobe is not used
    #1 d = cmd_rdata;
  endtask

  task automatic wait_done();
    logic [RW-1:0] s;
    int k;
    s = 8'h00;
    for (k = 0; k < 10 && s[0] !== 1'b1; k++) rd(H_STAT, s);
    for (k = 0; k < 3000 && !(s[0] === 1'b0 && s[1] === 1'b1); k++) rd(H_STAT, s);
    if (!(s[0] === 1'b0 && s[1] === 1'b1)) begin
      n_mismatch++;
      $display("BAD status wait ran out");
      test_done();
    end
  endtask

  task automatic reset_vals();
    logic [RW-1:0] v;
    rd(H_PCMF, v);
    chk("pcmf", v, PCMF_RST);
    rd(H_OCT, v);
    chk("oct", v, OCT_RST);
    rd(H_DEL, v);
    chk("del0", v, ZERO8);
    chk("unaligned", aligned, 1'b0);
  endtask

  // Fill the buffer while the device is not yet aligned and so stalls
  task automatic fill_fifo();
    in_valid <= 1'b1;
    in_data <= 16'hA000;
    repeat (40) begin
      @(posedge ref_clk);
      if (in_valid && in_ready) n_push++;
      in_data <= 16'hA000 + 16'(n_push);
    end
    in_valid <= 1'b0;
    chk("full", in_ready, 1'b0);
    chk("depth", n_push >= FIFO_D, 1'b1);
  endtask

  // One host run; expectations come from the pooled readings or the known delays
  task automatic run_sync(input logic subc, input logic known);
    logic [RW-1:0] v;
    int mn, mx, lmin, lmax, hmin, hmax, del, win, cnt;
    pool.delete();
    n_sysref = 0;
    lmin = 255;
    hmin = 255;
    lmax = -1;
    hmax = -1;
    wr(H_SUBC, {7'h00, subc});
    wr(H_LINK, 8'h4B);
    wr(H_FIXQ, 8'h0B);
    wr(H_VARQ, 8'h06);
    wr(H_CTRL, {6'h00, known, 1'b1});
    wait_done();
    chk("aligned", aligned, 1'b1);
    if (known) begin
      mn = 2; // Floor of 2.75 cycles
      mx = 5; // Ceiling of 4.25 cycles
    end else begin
      chk("readings", 16'(pool.size()), 16'd40);
      foreach (pool[i]) begin
        chk("range", pool[i] < PCMF_RST, 1'b1);
        if (pool[i] < 8) begin
          lmin = (pool[i] < lmin) ? pool[i] : lmin;
          lmax = (int'(pool[i]) > lmax) ? pool[i] : lmax;
        end else begin
          hmin = (pool[i] < hmin) ? pool[i] : hmin;
          hmax = (int'(pool[i]) > hmax) ? pool[i] : hmax;
        end
      end
      mn = (hmax < 0) ? lmin : hmin;
      mx = (lmax < 0) ? hmax : ((hmax < 0) ? lmax : lmax + 16);
    end
    del = subc ? ((((mn - 1) * 2) % 32) + 32) % 32 : (((mn - 1) % 16) + 16) % 16;
    win = (mx + 1) - (mn - 1);
    rd(H_MIN, v);
    chk("min", v, 16'(mn));
    rd(H_MAX, v);
    chk("max", v, 16'(mx));
    rd(H_DEL, v);
    chk("delay", v, 16'(del));
    rd(H_WIN, v);
    chk("window", v, 16'(win));
    rd(H_STAT, v);
    chk("wide", v[2], win > 10);
    chk("del sent", del_w, 16'(del));
    chk("win sent", win_w, 16'(win));
    if (subc) chk("edges", n_sysref > 0, 1'b1);
    if (!subc) begin
      cnt = 0;
      repeat (32) begin
        @(posedge ref_clk);
        #1 cnt += int'(release_pulse);
      end
      chk("release", 16'(cnt), 16'd2);
    end
  endtask

  task automatic stream_check();
    repeat (40) @(posedge ref_clk);
    chk("words", 16'(got_q.size()), 16'(n_push));
    foreach (got_q[i]) chk("word", got_q[i], 16'hA000 + 16'(i));
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    reset_vals();
    fill_fifo();
    run_sync(1'b0, 1'b0);
    run_sync(1'b1, 1'b0);
    run_sync(1'b0, 1'b1);
    stream_check();
    test_done();
  end
endmodule
